// ==== cache_mmu_bus_port.sv ====
// Cache controller end of the processor virtual bus: hold, strobe, exception, reset and intervene.
`timescale 1ns/1ps
module cache_mmu_bus_port (
  // Virtual bus.
  vbus_if.device vb,
  // Cache lookup and fill, and the processor reset request.
  input wire logic cache_hit,
  input wire logic prot_violation,
  input wire logic fill_done,
  input wire logic iu_reset_req,
  // Coherent snoop from the system bus side.
  input wire logic sysbus_addr_strobe_n,
  input wire logic snoop_coh_read,
  input wire logic snoop_owned,
  input wire logic owner_data_ready,
  input wire logic owned_data_read,
  // Cache RAM and access status.
  output logic cache_ram_read_oe_n,
  output vbus_pkg::lanes_t cache_ram_byte_we_n,
  output logic miss_req,
  output logic acc_atomic,
  output vbus_pkg::size_t acc_size,
  output logic bus_release
);
  import vbus_pkg::*;

  logic clk_sys;
  logic rst_n;
  assign clk_sys = vb.clk_sys;
  assign rst_n = vb.rst_n;

  acc_state_e state_ff;
  acc_state_e nxt_state;
  snoop_state_e snoop_ff;
  snoop_state_e nxt_snoop;

  logic rd_ff;
  logic wr_ff;
  logic live_ff;
  logic [1:0] wait_cnt_ff;
  logic intervene_ff;
  logic foreign_ff;
  logic foreign_d_ff;
  logic hold_req;
  logic iu_reset_n_ff;
  logic mem_hold_n_ff;
  logic mem_data_strobe_n_ff;
  logic mem_exception_n_ff;
  logic read_oe_n_ff;
  lanes_t byte_we_n_ff;
  logic miss_req_ff;
  logic atomic_ff;
  size_t size_ff;

  // Sampling of the processor's cycle indicators on the rising edge.
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rd_ff <= 1'b0;
      wr_ff <= 1'b0;
      live_ff <= 1'b0;
      atomic_ff <= 1'b0;
      size_ff <= SIZE_RST;
    end
    else
    begin
      rd_ff <= vb.rd_a;
      wr_ff <= !vb.we_n;
      atomic_ff <= vb.atomic_ind_a;
      size_ff <= vb.size;
      live_ff <= vb.sys_nullify_n;
    end
  end

  // A new access is only looked at while idle; a nullified one is dropped entirely.
  always_comb
  begin
    nxt_state = state_ff;
    unique case (state_ff)
      ST_IDLE:
      begin
        if ((rd_ff || wr_ff) && live_ff && vb.iu_reset_n)
        begin
          if (prot_violation)
            nxt_state = ST_EXC;
          else if (rd_ff && !cache_hit)
            nxt_state = ST_MISS;
        end
      end
      ST_MISS:
      begin
        if (fill_done)
          nxt_state = ST_STROBE;
      end
      ST_STROBE: nxt_state = ST_IDLE;
      ST_EXC: nxt_state = ST_IDLE;
      default: nxt_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      state_ff <= ST_IDLE;
    else
      state_ff <= nxt_state;
  end

  // Miss request to the fill logic, one cycle on entry to the miss state.
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      miss_req_ff <= 1'b0;
    else
      miss_req_ff <= (state_ff == ST_IDLE) && (nxt_state == ST_MISS);
  end

  // Cache RAM read enable comes from the bus indicators, write enables from the sampled ones, gated so a dropped access changes nothing.
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      read_oe_n_ff <= 1'b1;
      byte_we_n_ff <= LANES_OFF_N;
    end
    else
    begin
      read_oe_n_ff <= !(vb.rd_a && vb.sys_nullify_n);
      if (state_ff == ST_IDLE && wr_ff && live_ff && cache_hit && !prot_violation)
        byte_we_n_ff <= lane_mask_n(size_ff, vb.vaddr_lo);
      else
        byte_we_n_ff <= LANES_OFF_N;
    end
  end

  // Snoop side: intervene on a coherent read of an owned line, no sooner than the second cycle.
  always_comb
  begin
    nxt_snoop = snoop_ff;
    unique case (snoop_ff)
      SN_IDLE:
      begin
        if (!sysbus_addr_strobe_n && snoop_coh_read && snoop_owned)
          nxt_snoop = SN_WAIT;
      end
      SN_WAIT:
      begin
        if (wait_cnt_ff == INTERVENE_DELAY - 2'h1 && owner_data_ready)
          nxt_snoop = SN_OWN;
      end
      SN_OWN:
      begin
        if (owned_data_read)
          nxt_snoop = SN_IDLE;
      end
      default: nxt_snoop = SN_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      snoop_ff <= SN_IDLE;
    else
      snoop_ff <= nxt_snoop;
  end

  // The wait counter saturates, so a busy owner simply asserts later.
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      wait_cnt_ff <= 2'h0;
    else if (snoop_ff != SN_WAIT)
      wait_cnt_ff <= 2'h0;
    else if (wait_cnt_ff != INTERVENE_DELAY - 2'h1)
      wait_cnt_ff <= wait_cnt_ff + 2'h1;
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      intervene_ff <= 1'b0;
    else
      intervene_ff <= (nxt_snoop == SN_OWN);
  end

  // Another controller owns the bus: stand off and hold one cycle past its release.
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      foreign_ff <= 1'b0;
      foreign_d_ff <= 1'b0;
    end
    else
    begin
      foreign_ff <= !vb.owner_intervene_n && !intervene_ff;
      foreign_d_ff <= foreign_ff;
    end
  end

  assign hold_req = (state_ff != ST_IDLE) || foreign_ff || foreign_d_ff;

  // Hold, strobe and exception launch on the falling edge, half a cycle after the state settles.
  always_ff @(negedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mem_hold_n_ff <= 1'b1;
      mem_data_strobe_n_ff <= 1'b1;
      mem_exception_n_ff <= 1'b1;
    end
    else
    begin
      mem_hold_n_ff <= !hold_req;
      mem_data_strobe_n_ff <= !(state_ff == ST_STROBE || state_ff == ST_EXC);
      mem_exception_n_ff <= !(state_ff == ST_EXC);
    end
  end

  // Reset to the integer unit is held asserted through our own reset and always driven.
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      iu_reset_n_ff <= 1'b0;
    else
      iu_reset_n_ff <= !iu_reset_req;
  end

  assign vb.iu_reset_n = iu_reset_n_ff;
  assign vb.mem_hold_n = mem_hold_n_ff;
  assign vb.mem_data_strobe_n = mem_data_strobe_n_ff;
  assign vb.mem_exception_n = mem_exception_n_ff;
  assign vb.owner_intervene_n_o = 1'b0;
  assign vb.owner_intervene_oe = intervene_ff;
  assign cache_ram_read_oe_n = read_oe_n_ff;
  assign cache_ram_byte_we_n = byte_we_n_ff;
  assign miss_req = miss_req_ff;
  assign acc_atomic = atomic_ff;
  assign acc_size = size_ff;
  assign bus_release = foreign_ff;

endmodule : cache_mmu_bus_port

// ==== iu_bus_master.sv ====
// Processor end of the virtual bus: drives cycle indicators and takes hold, strobe and exception.
`timescale 1ns/1ps
module iu_bus_master (
  // Virtual bus.
  vbus_if.cpu vb,
  // Access requests.
  input wire logic req_valid,
  input wire logic req_read,
  input wire logic req_atomic,
  input wire vbus_pkg::size_t req_size,
  input wire logic [1:0] req_off,
  input wire logic req_nullify,
  output logic req_ready,
  // Results.
  output logic data_taken,
  output logic mem_fault,
  output logic in_reset
);
  import vbus_pkg::*;

  logic rd_ff;
  logic we_n_ff;
  logic atomic_ff;
  size_t size_ff;
  logic [1:0] off_ff;
  logic null_n_ff;
  logic taken_ff;
  logic fault_ff;

  // A held cycle keeps its indicators steady until the hold lifts.
  assign req_ready = vb.mem_hold_n && vb.iu_reset_n;

  always_ff @(posedge vb.clk_sys or negedge vb.rst_n)
  begin
    if (!vb.rst_n)
    begin
      rd_ff <= 1'b0;
      we_n_ff <= 1'b1;
      atomic_ff <= 1'b0;
      size_ff <= SIZE_RST;
      off_ff <= 2'h0;
      null_n_ff <= 1'b1;
    end
    else if (req_ready)
    begin
      rd_ff <= req_valid && req_read;
      we_n_ff <= !(req_valid && !req_read);
      atomic_ff <= req_valid && req_atomic;
      size_ff <= req_size;
      off_ff <= req_off;
      null_n_ff <= !req_nullify;
    end
    else if (!vb.iu_reset_n)
    begin
      rd_ff <= 1'b0;
      we_n_ff <= 1'b1;
      atomic_ff <= 1'b0;
    end
  end

  // Strobe and exception are taken on the rising edge after the falling-edge launch.
  always_ff @(posedge vb.clk_sys or negedge vb.rst_n)
  begin
    if (!vb.rst_n)
    begin
      taken_ff <= 1'b0;
      fault_ff <= 1'b0;
    end
    else
    begin
      taken_ff <= !vb.mem_data_strobe_n && vb.mem_exception_n;
      fault_ff <= !vb.mem_exception_n;
    end
  end

  assign vb.rd_a = rd_ff;
  assign vb.we_n = we_n_ff;
  assign vb.atomic_ind_a = atomic_ff;
  assign vb.size = size_ff;
  assign vb.vaddr_lo = off_ff;
  assign vb.sys_nullify_n = null_n_ff;
  assign data_taken = taken_ff;
  assign mem_fault = fault_ff;
  assign in_reset = !vb.iu_reset_n;

endmodule : iu_bus_master

// ==== tb_top.sv ====
// Self-checking bench joining the processor end and the controller end.
`timescale 1ns/1ps
module tb_top;
  import vbus_pkg::*;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b1;
  logic cache_hit = 1'b1, prot_violation = 1'b0, fill_done = 1'b0, iu_reset_req = 1'b0;
  logic sysbus_addr_strobe_n = 1'b1, snoop_coh_read = 1'b1, snoop_owned = 1'b1;
  logic owner_data_ready = 1'b1, owned_data_read = 1'b0;
  logic cache_ram_read_oe_n, miss_req, acc_atomic, bus_release;
  lanes_t cache_ram_byte_we_n;
  size_t acc_size;
  logic req_valid = 1'b0, req_read = 1'b0, req_atomic = 1'b0, req_nullify = 1'b0;
  size_t req_size = SIZE_WORD;
  logic [1:0] req_off = 2'h0;
  logic req_ready, data_taken, mem_fault, in_reset;
  int num_errors = 0;
  int cmp_count = 0;
  int cycles = 0;
  int nstb, nexc, nmiss, ndone, natm;
  lanes_t we;
  logic oe, hold;
  vbus_if vb (.clk_sys(clk_sys), .rst_n(rst_n));
  cache_mmu_bus_port i_cache_mmu_bus_port (.vb(vb.device), .cache_hit(cache_hit),
    .prot_violation(prot_violation), .fill_done(fill_done), .iu_reset_req(iu_reset_req),
    .sysbus_addr_strobe_n(sysbus_addr_strobe_n), .snoop_coh_read(snoop_coh_read), .snoop_owned(snoop_owned),
    .owner_data_ready(owner_data_ready), .owned_data_read(owned_data_read),
    .cache_ram_read_oe_n(cache_ram_read_oe_n), .cache_ram_byte_we_n(cache_ram_byte_we_n),
    .miss_req(miss_req), .acc_atomic(acc_atomic), .acc_size(acc_size), .bus_release(bus_release));
  iu_bus_master i_iu_bus_master (.vb(vb.cpu), .req_valid(req_valid), .req_read(req_read),
    .req_atomic(req_atomic), .req_size(req_size), .req_off(req_off), .req_nullify(req_nullify),
    .req_ready(req_ready), .data_taken(data_taken), .mem_fault(mem_fault), .in_reset(in_reset));
  vbus_assertions i_vbus_assertions (.clk_sys(clk_sys), .rst_n(rst_n), .rd_a(vb.rd_a),
    .sys_nullify_n(vb.sys_nullify_n), .iu_reset_n(vb.iu_reset_n), .mem_hold_n(vb.mem_hold_n),
    .mem_data_strobe_n(vb.mem_data_strobe_n), .mem_exception_n(vb.mem_exception_n),
    .owner_intervene_oe(vb.owner_intervene_oe), .other_intervene_n(vb.other_intervene_n),
    .owner_intervene_n(vb.owner_intervene_n));
  always #20 clk_sys = ~clk_sys;
  task cyc(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : cyc
  task chk(input string nm, input logic [3:0] exp, input logic [3:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  // Accumulates what the controller shows; strobes change on the falling edge, so each sample is settled.
  task watch(input int n);
    repeat (n)
    begin
      cyc(1);
      we &= cache_ram_byte_we_n;
      oe &= cache_ram_read_oe_n;
      hold &= vb.mem_hold_n;
      nstb += int'(vb.mem_data_strobe_n === 1'b0);
      nexc += int'(vb.mem_exception_n === 1'b0);
      nmiss += int'(miss_req === 1'b1);
      natm += int'(acc_atomic === 1'b1);
      ndone += int'(data_taken === 1'b1 || mem_fault === 1'b1);
    end
  endtask : watch
  task run(input logic rd, nl, input size_t sz, input logic [1:0] off);
    {nstb, nexc, nmiss, ndone, natm} = '0;
    {we, oe, hold} = 6'h3f;
    {req_read, req_nullify, req_size, req_off, req_valid} = {rd, nl, sz, off, 1'b1};
    cyc(1);
    req_valid = 1'b0;
    watch(6);
  endtask : run
  task t_reset;
    chk("iu_reset_n", 4'h1, 4'(vb.iu_reset_n));
    iu_reset_req = 1'b1;
    cyc(2);
    chk("iu_reset_n", 4'h0, 4'(vb.iu_reset_n));
    chk("in_reset", 4'h1, 4'(in_reset));
    iu_reset_req = 1'b0;
    cyc(2);
    $display("test reset done");
  endtask : t_reset
  task automatic t_hits;
    size_t szs [6] = '{SIZE_BYTE, SIZE_BYTE, SIZE_HALF, SIZE_HALF, SIZE_WORD, SIZE_DBL};
    logic [1:0] offs [6] = '{2'h0, 2'h1, 2'h2, 2'h0, 2'h0, 2'h0};
    lanes_t exp [6] = '{4'h7, 4'hb, 4'hc, 4'h3, 4'h0, 4'h0};
    for (int i = 0; i < 6; i++)
    begin
      run(1'b0, 1'b0, szs[i], offs[i]);
      chk("byte_we_n", exp[i], we);
    end
    run(1'b1, 1'b0, SIZE_WORD, 2'h0);
    chk("read_oe_n", 4'h0, 4'(oe));
    $display("test hits done");
  endtask : t_hits
  // A nullified miss is the awkward case: it would otherwise stall the processor.
  task t_null;
    cache_hit = 1'b0;
    run(1'b1, 1'b1, SIZE_WORD, 2'h0);
    chk("null_hold", 4'h1, 4'(hold));
    chk("null_oe", 4'h1, 4'(oe));
    chk("null_miss", 4'h0, 4'(nmiss));
    run(1'b0, 1'b1, SIZE_BYTE, 2'h1);
    chk("null_we", 4'hf, we);
    $display("test null done");
  endtask : t_null
  task t_miss;
    req_atomic = 1'b1;
    run(1'b1, 1'b0, SIZE_DBL, 2'h0);
    req_atomic = 1'b0;
    chk("miss_req", 4'h1, 4'(nmiss));
    chk("miss_hold", 4'h0, 4'(vb.mem_hold_n));
    chk("acc_size", 4'(SIZE_DBL), 4'(acc_size));
    chk("acc_atomic", 4'h1, 4'(natm));
    {nstb, ndone} = '0;
    fill_done = 1'b1;
    cyc(1);
    fill_done = 1'b0;
    watch(6);
    chk("strobes", 4'h1, 4'(nstb));
    chk("taken", 4'h1, 4'(ndone));
    chk("hold_end", 4'h1, 4'(vb.mem_hold_n));
    cache_hit = 1'b1;
    $display("test miss done");
  endtask : t_miss
  task t_fault;
    prot_violation = 1'b1;
    run(1'b1, 1'b0, SIZE_WORD, 2'h0);
    prot_violation = 1'b0;
    chk("exceptions", 4'h1, 4'(nexc));
    chk("fault", 4'h1, 4'(ndone));
    chk("exc_hold", 4'h0, 4'(hold));
    $display("test fault done");
  endtask : t_fault
  task t_snoop;
    snoop_owned = 1'b0;
    sysbus_addr_strobe_n = 1'b0;
    cyc(1);
    sysbus_addr_strobe_n = 1'b1;
    snoop_owned = 1'b1;
    cyc(3);
    chk("oe_unowned", 4'h0, 4'(vb.owner_intervene_oe));
    sysbus_addr_strobe_n = 1'b0;
    cyc(1);
    sysbus_addr_strobe_n = 1'b1;
    cyc(1);
    chk("oe_first", 4'h0, 4'(vb.owner_intervene_oe));
    cyc(1);
    chk("oe_second", 4'h1, 4'(vb.owner_intervene_oe));
    chk("line", 4'h0, 4'(vb.owner_intervene_n));
    cyc(3);
    chk("oe_kept", 4'h1, 4'(vb.owner_intervene_oe));
    owned_data_read = 1'b1;
    cyc(1);
    owned_data_read = 1'b0;
    cyc(1);
    chk("oe_off", 4'h0, 4'(vb.owner_intervene_oe));
    // A busy owner must hold off until its data is ready, then intervene late.
    owner_data_ready = 1'b0;
    sysbus_addr_strobe_n = 1'b0;
    cyc(1);
    sysbus_addr_strobe_n = 1'b1;
    cyc(2);
    chk("oe_busy", 4'h0, 4'(vb.owner_intervene_oe));
    owner_data_ready = 1'b1;
    cyc(1);
    chk("oe_late", 4'h1, 4'(vb.owner_intervene_oe));
    owned_data_read = 1'b1;
    cyc(1);
    owned_data_read = 1'b0;
    cyc(1);
    chk("oe_late_off", 4'h0, 4'(vb.owner_intervene_oe));
    $display("test snoop done");
  endtask : t_snoop
  task t_foreign;
    vb.other_intervene_n = 1'b0;
    cyc(3);
    chk("release", 4'h1, 4'(bus_release));
    chk("fhold", 4'h0, 4'(vb.mem_hold_n));
    vb.other_intervene_n = 1'b1;
    cyc(2);
    chk("fhold_tail", 4'h0, 4'(vb.mem_hold_n));
    cyc(3);
    chk("fhold_end", 4'h1, 4'(vb.mem_hold_n));
    $display("test foreign done");
  endtask : t_foreign
  task conclude;
    $display("checks %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : conclude
  // The run needs under 150 cycles; the ceiling of 3000 leaves ample margin.
  always @(posedge clk_sys)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      num_errors++;
      conclude();
    end
  end
  initial
  begin
    vb.other_intervene_n = 1'b1;
    // A real falling reset edge before the first clock makes every asynchronous reset branch run.
    #5 rst_n = 1'b0;
    cyc(20);
    rst_n = 1'b1;
    cyc(2);
    t_reset();
    t_hits();
    t_null();
    t_miss();
    t_fault();
    t_snoop();
    t_foreign();
    conclude();
  end
endmodule : tb_top

// ==== vbus_assertions.sv ====
// Concurrent checks on the virtual-bus signals between the two ends.
`timescale 1ns/1ps
module vbus_assertions (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic rst_n,
  // Processor side.
  input wire logic rd_a,
  input wire logic sys_nullify_n,
  // Controller side.
  input wire logic iu_reset_n,
  input wire logic mem_hold_n,
  input wire logic mem_data_strobe_n,
  input wire logic mem_exception_n,
  // Intervene line.
  input wire logic owner_intervene_oe,
  input wire logic other_intervene_n,
  input wire logic owner_intervene_n
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);
  sequence s_strobe_pulse;
    $fell(mem_data_strobe_n) ##1 mem_data_strobe_n;
  endsequence
  sequence s_quiet_two;
    (mem_hold_n && mem_data_strobe_n && mem_exception_n) [*2];
  endsequence
  a_strobe_needs_hold: assert property (!mem_data_strobe_n |-> !mem_hold_n)
    else $error("strobe low without hold");
  a_strobe_one_clk: assert property ($fell(mem_data_strobe_n) |=> mem_data_strobe_n)
    else $error("strobe longer than one clock");
  a_hold_ends_strobe: assert property (s_strobe_pulse |-> mem_hold_n)
    else $error("hold not released after strobe");
  a_exc_all_low: assert property (!mem_exception_n |-> !mem_hold_n && !mem_data_strobe_n)
    else $error("exception without hold and strobe");
  a_exc_one_clk: assert property ($fell(mem_exception_n) |=> mem_exception_n)
    else $error("exception longer than one clock");
  a_iu_reset_low: assert property (disable iff (1'b0) !rst_n |-> !iu_reset_n)
    else $error("processor reset not driven low");
  a_null_stays_quiet: assert property (mem_hold_n && iu_reset_n && rd_a && !sys_nullify_n |=> s_quiet_two)
    else $error("nullified access answered");
  a_owner_pulls_line: assert property (owner_intervene_oe |-> !owner_intervene_n)
    else $error("intervene line not pulled");
  a_foreign_hold: assert property (!other_intervene_n && !owner_intervene_oe |-> ##2 !mem_hold_n)
    else $error("no hold on foreign intervene");
  a_hold_extra_cycle: assert property ($rose(other_intervene_n) |=> !mem_hold_n ##[1:3] mem_hold_n)
    else $error("hold tail after intervene wrong");
endmodule : vbus_assertions

// ==== vbus_if.sv ====
// Virtual-bus signals between the processor end and the cache controller end.
`timescale 1ns/1ps
interface vbus_if
  import vbus_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_n
);
  // Processor to controller.
  logic atomic_ind_a;
  logic rd_a;
  logic we_n;
  size_t size;
  logic [1:0] vaddr_lo;
  logic sys_nullify_n;
  // Controller to processor.
  logic iu_reset_n;
  logic mem_hold_n;
  logic mem_data_strobe_n;
  logic mem_exception_n;
  // Shared open-drain intervene line among controllers.
  logic owner_intervene_n_o;
  logic owner_intervene_oe;
  logic other_intervene_n;
  logic owner_intervene_n;

  // Pulled high; any driver or another controller pulls it low.
  assign owner_intervene_n = (owner_intervene_oe ? owner_intervene_n_o : 1'b1) & other_intervene_n;

  modport device (
    input clk_sys, rst_n, atomic_ind_a, rd_a, we_n, size, vaddr_lo, sys_nullify_n, owner_intervene_n,
    output iu_reset_n, mem_hold_n, mem_data_strobe_n, mem_exception_n, owner_intervene_n_o,
    owner_intervene_oe
  );

  modport cpu (
    input clk_sys, rst_n, iu_reset_n, mem_hold_n, mem_data_strobe_n, mem_exception_n,
    output atomic_ind_a, rd_a, we_n, size, vaddr_lo, sys_nullify_n
  );

endinterface : vbus_if

// ==== vbus_pkg.sv ====
// Constants and types shared by both ends of the processor virtual-bus port.
package vbus_pkg;

  typedef logic [1:0] size_t;
  typedef logic [3:0] lanes_t;

  // Access size codes carried on the size lines.
  localparam size_t SIZE_BYTE = 2'h0;
  localparam size_t SIZE_HALF = 2'h1;
  localparam size_t SIZE_WORD = 2'h2;
  localparam size_t SIZE_DBL = 2'h3;

  // Values after reset.
  localparam lanes_t LANES_OFF_N = 4'hf;
  localparam size_t SIZE_RST = 2'h2;

  // Cycles from the sampled address strobe to the earliest intervene.
  localparam logic [1:0] INTERVENE_DELAY = 2'h2;

  typedef enum logic [2:0] {ST_IDLE, ST_MISS, ST_STROBE, ST_EXC} acc_state_e;
  typedef enum logic [1:0] {SN_IDLE, SN_WAIT, SN_OWN} snoop_state_e;

  // Active-low byte lanes touched by an access; lane 3 is the lowest address.
  function automatic lanes_t lane_mask_n(input size_t sz, input logic [1:0] off);
    lanes_t m;
    m = 4'h0;
    unique case (sz)
      SIZE_BYTE: m = lanes_t'(4'h8 >> off);
      SIZE_HALF: m = off[1] ? 4'h3 : 4'hc;
      SIZE_WORD: m = 4'hf;
      SIZE_DBL: m = 4'hf;
    endcase
    return ~m;
  endfunction : lane_mask_n

endpackage : vbus_pkg
